// [rtl/cantx_defs.svh]
// register offsets, field positions, reset values and codes of the tx order/cancel block
`ifndef CANTX_DEFS_SVH
`define CANTX_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CANTX_OFF_CTRL 12'h000
`define CANTX_OFF_ADD 12'h004
`define CANTX_OFF_CANCEL 12'h008
`define CANTX_OFF_PEND 12'h00C
`define CANTX_OFF_CFIN 12'h010
`define CANTX_OFF_TOCC 12'h014
`define CANTX_OFF_PUT 12'h018
`define CANTX_OFF_STAT 12'h01C
`define CANTX_FLT_BASE 12'h100

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define CANTX_CTRL_W 5
`define CANTX_CTRL_RESET 5'h00
`define CANTX_CTRL_DAR 0
`define CANTX_CTRL_ANFS_LSB 1
`define CANTX_CTRL_ANFE_LSB 3
`define CANTX_STAT_HPM 0
`define CANTX_STAT_BUSY 1
`define CANTX_STAT_BUF_LSB 8
`define CANTX_PUT_FULL 8

// ----------------------------------------------------------------
// filter element words: word 0 = config + compare, word 1 = type + kind + mask
// ----------------------------------------------------------------
`define CANTX_FE_CFG_LSB 29
`define CANTX_FE_TYPE_LSB 30
`define CANTX_FE_EXT 29
`define CANTX_FE_ID_MSB 28
`define CANTX_STD_ID_MSB 10
`define CANTX_TYPE_CLASSIC 2'h2
`define CANTX_ANF_FIFO0 2'h0
`define CANTX_ANF_FIFO1 2'h1

`endif

// [rtl/cantx_pkg.sv]
// types shared by the tx order/cancel block
package cantx_pkg;

    typedef enum logic [0:0] {
        CANTX_TX_IDLE = 1'b0,
        CANTX_TX_ACTIVE = 1'b1
    } cantx_tx_state_t;

    typedef enum logic [0:0] {
        CANTX_FLT_IDLE = 1'b0,
        CANTX_FLT_SCAN = 1'b1
    } cantx_flt_state_t;

    typedef enum logic [2:0] {
        CANTX_FCFG_OFF = 3'b000,
        CANTX_FCFG_FIFO0 = 3'b001,
        CANTX_FCFG_FIFO1 = 3'b010,
        CANTX_FCFG_REJECT = 3'b011,
        CANTX_FCFG_PRIO = 3'b100,
        CANTX_FCFG_PRIO_F0 = 3'b101,
        CANTX_FCFG_PRIO_F1 = 3'b110,
        CANTX_FCFG_RSVD = 3'b111
    } cantx_fcfg_t;

endpackage : cantx_pkg

// [rtl/cantx_filter_mem.sv]
// single-port filter element memory with registered read data
`timescale 1ns/1ns
module cantx_filter_mem #(
    parameter int W = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic we,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata_ff
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= mem[addr];
        end
    end
endmodule : cantx_filter_mem

// [rtl/cantx_order_cancel.sv]
// tx buffer ordering, cancellation and catch-all acceptance filtering with apb registers
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "cantx_defs.svh"
module cantx_order_cancel #(
    parameter int NBUF = 32,
    parameter int QFIRST = 16,
    parameter int NFLT = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_ok,
    input wire logic tx_fail,
    output logic tx_start,
    output logic [$clog2(NBUF)-1:0] tx_buf,
    input wire logic rx_valid,
    input wire logic rx_ext,
    input wire logic [28:0] rx_id,
    output logic rx_accept,
    output logic rx_fifo_sel,
    output logic rx_reject
);
    localparam int BW = $clog2(NBUF);
    localparam int FD = 2 * NFLT;
    localparam int FAW = $clog2(FD);
    localparam logic [FAW:0] FD_W = (FAW + 1)'(FD);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [BW:0] lowest_set(input logic [NBUF-1:0] v);
        logic [BW:0] r;
        r = '0;
        for (int i = NBUF - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, BW'(i)};
            end
        end
        return r;
    endfunction : lowest_set

    function automatic logic [NBUF-1:0] below(input logic [BW-1:0] k);
        logic [NBUF-1:0] m;
        m = '0;
        for (int i = 0; i < NBUF; i++) begin
            m[i] = (BW'(i) < k);
        end
        return m;
    endfunction : below

    localparam logic [NBUF-1:0] QMASK = ~below(BW'(QFIRST));

    // ----------------------------------------------------------------
    // apb slave: one wait state, write takes effect with pready
    // ----------------------------------------------------------------
    logic [`CANTX_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [NBUF-1:0] pend_ff, cf_ff, to_ff, creq_ff;
    logic [BW-1:0] put_idx_ff;
    logic put_full_ff;
    logic hpm_ff;
    logic [BW-1:0] cur_ff;
    cantx_pkg::cantx_tx_state_t tx_state_ff;
    logic [31:0] mem_rdata;
    logic [11:0] flt_off;
    logic in_flt, apply_wr, hpm_clr;
    logic [NBUF-1:0] add_new, cancel_new;

    assign flt_off = paddr - `CANTX_FLT_BASE;
    assign in_flt = (paddr >= `CANTX_FLT_BASE) && (flt_off[11:2] < 10'(FD));
    assign apply_wr = psel && penable && pready_ff && pwrite;
    assign hpm_clr = apply_wr && (paddr == `CANTX_OFF_STAT) && pwdata[`CANTX_STAT_HPM];
    // only buffers not already pending accept an add; cancel only hits pending ones
    assign add_new = (apply_wr && paddr == `CANTX_OFF_ADD) ? pwdata[NBUF-1:0] & ~pend_ff : '0;
    assign cancel_new = (apply_wr && paddr == `CANTX_OFF_CANCEL) ? pwdata[NBUF-1:0] & pend_ff : '0;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        if (psel && penable && !pready_ff) begin
            nxt_pready = 1'b1;
            nxt_prdata = 32'h0000_0000;
            if (paddr == `CANTX_OFF_CTRL) begin
                nxt_prdata = 32'(ctrl_ff);
            end else if (paddr == `CANTX_OFF_ADD) begin
                nxt_prdata = 32'h0000_0000;
            end else if (paddr == `CANTX_OFF_CANCEL) begin
                nxt_prdata = 32'(creq_ff);
            end else if (paddr == `CANTX_OFF_PEND) begin
                nxt_prdata = 32'(pend_ff);
            end else if (paddr == `CANTX_OFF_CFIN) begin
                nxt_prdata = 32'(cf_ff);
            end else if (paddr == `CANTX_OFF_TOCC) begin
                nxt_prdata = 32'(to_ff);
            end else if (paddr == `CANTX_OFF_PUT) begin
                nxt_prdata = 32'(put_idx_ff);
                nxt_prdata[`CANTX_PUT_FULL] = put_full_ff;
            end else if (paddr == `CANTX_OFF_STAT) begin
                nxt_prdata[`CANTX_STAT_HPM] = hpm_ff;
                nxt_prdata[`CANTX_STAT_BUSY] = (tx_state_ff == cantx_pkg::CANTX_TX_ACTIVE);
                nxt_prdata[`CANTX_STAT_BUF_LSB +: BW] = cur_ff;
            end else if (in_flt) begin
                nxt_prdata = mem_rdata;
            end else begin
                nxt_pslverr = 1'b1;
            end
        end
        if (apply_wr && paddr == `CANTX_OFF_CTRL) begin
            nxt_ctrl = pwdata[`CANTX_CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CANTX_CTRL_RESET;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // ----------------------------------------------------------------
    // tx buffer handling
    // ----------------------------------------------------------------
    logic [NBUF-1:0] nxt_pend, nxt_cf, nxt_to, nxt_creq;
    logic [BW-1:0] nxt_cur, nxt_put_idx;
    logic nxt_put_full, tx_start_ff, nxt_tx_start;
    cantx_pkg::cantx_tx_state_t nxt_tx_state;
    logic [BW:0] sel, free_sel;

    assign sel = lowest_set(pend_ff);
    assign free_sel = lowest_set(~pend_ff & QMASK);

    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_cur = cur_ff;
        nxt_tx_start = 1'b0;
        // adds first so that a hardware set below wins over the add's clear
        nxt_pend = pend_ff | add_new;
        nxt_cf = cf_ff & ~add_new;
        nxt_to = to_ff & ~add_new;
        nxt_creq = (creq_ff & ~add_new) | cancel_new;
        nxt_put_idx = free_sel[BW-1:0];
        nxt_put_full = !free_sel[BW];
        case (tx_state_ff)
            cantx_pkg::CANTX_TX_IDLE: begin
                if (sel[BW]) begin
                    if (nxt_creq[sel[BW-1:0]]) begin
                        // not yet on the bus, so cancellation completes at once
                        nxt_pend[sel[BW-1:0]] = 1'b0;
                        nxt_cf[sel[BW-1:0]] = 1'b1;
                        nxt_creq[sel[BW-1:0]] = 1'b0;
                    end else begin
                        nxt_tx_start = 1'b1;
                        nxt_cur = sel[BW-1:0];
                        nxt_tx_state = cantx_pkg::CANTX_TX_ACTIVE;
                    end
                end
            end
            cantx_pkg::CANTX_TX_ACTIVE: begin
                // pending stays set during the frame, so software cannot reuse the buffer
                if (tx_ok) begin
                    nxt_pend[cur_ff] = 1'b0;
                    nxt_to[cur_ff] = 1'b1;
                    nxt_creq[cur_ff] = 1'b0;
                    nxt_tx_state = cantx_pkg::CANTX_TX_IDLE;
                end else if (tx_fail) begin
                    if (ctrl_ff[`CANTX_CTRL_DAR] || nxt_creq[cur_ff]) begin
                        nxt_pend[cur_ff] = 1'b0;
                        nxt_cf[cur_ff] = 1'b1;
                        nxt_creq[cur_ff] = 1'b0;
                    end
                    // otherwise pending remains and the idle pick retries it
                    nxt_tx_state = cantx_pkg::CANTX_TX_IDLE;
                end
            end
            default: nxt_tx_state = cantx_pkg::CANTX_TX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_ff <= cantx_pkg::CANTX_TX_IDLE;
            cur_ff <= '0;
            tx_start_ff <= 1'b0;
            pend_ff <= '0;
            cf_ff <= '0;
            to_ff <= '0;
            creq_ff <= '0;
            put_idx_ff <= '0;
            put_full_ff <= 1'b0;
        end else begin
            tx_state_ff <= nxt_tx_state;
            cur_ff <= nxt_cur;
            tx_start_ff <= nxt_tx_start;
            pend_ff <= nxt_pend;
            cf_ff <= nxt_cf;
            to_ff <= nxt_to;
            creq_ff <= nxt_creq;
            put_idx_ff <= nxt_put_idx;
            put_full_ff <= nxt_put_full;
        end
    end

    // ----------------------------------------------------------------
    // acceptance filter scan
    // ----------------------------------------------------------------
    cantx_pkg::cantx_flt_state_t flt_state_ff, nxt_flt_state;
    logic [FAW:0] rd_idx_ff, nxt_rd_idx;
    logic rd_pend_ff, nxt_rd_pend;
    logic [31:0] w0_ff, nxt_w0;
    logic rx_ext_ff, nxt_rx_ext;
    logic [28:0] rx_id_ff, nxt_rx_id;
    logic acc_ff, nxt_acc, fsel_ff, nxt_fsel, rej_ff, nxt_rej, nxt_hpm;
    logic [FAW-1:0] mem_addr;
    logic [FAW:0] ev_idx;
    logic ev_now, ev_kind, ev_hit, ev_last;
    logic [28:0] idmask;
    cantx_pkg::cantx_fcfg_t ev_cfg;
    logic [1:0] anf;

    assign mem_addr = psel ? flt_off[FAW+1:2] : rd_idx_ff[FAW-1:0];
    assign ev_idx = rd_idx_ff - (FAW + 1)'(1);
    assign ev_now = (flt_state_ff == cantx_pkg::CANTX_FLT_SCAN) && rd_pend_ff && ev_idx[0];
    assign ev_last = (ev_idx == FD_W - (FAW + 1)'(1));
    assign ev_cfg = cantx_pkg::cantx_fcfg_t'(w0_ff[`CANTX_FE_CFG_LSB +: 3]);
    assign ev_kind = (mem_rdata[`CANTX_FE_EXT] == rx_ext_ff);
    assign idmask = rx_ext_ff ? 29'h1FFF_FFFF : 29'h0000_07FF;
    // masked compare: a zero mask ignores every id bit and so catches all frames of the element's id kind
    assign ev_hit = ev_kind && (ev_cfg != cantx_pkg::CANTX_FCFG_OFF)
        && (mem_rdata[`CANTX_FE_TYPE_LSB +: 2] == `CANTX_TYPE_CLASSIC)
        && (((rx_id_ff ^ w0_ff[`CANTX_FE_ID_MSB:0]) & mem_rdata[`CANTX_FE_ID_MSB:0]
        & idmask) == 29'h0000_0000);
    assign anf = rx_ext_ff ? ctrl_ff[`CANTX_CTRL_ANFE_LSB +: 2] : ctrl_ff[`CANTX_CTRL_ANFS_LSB +: 2];

    always_comb begin
        nxt_flt_state = flt_state_ff;
        nxt_rd_idx = rd_idx_ff;
        nxt_rd_pend = 1'b0;
        nxt_w0 = w0_ff;
        nxt_rx_ext = rx_ext_ff;
        nxt_rx_id = rx_id_ff;
        nxt_acc = 1'b0;
        nxt_fsel = fsel_ff;
        nxt_rej = 1'b0;
        nxt_hpm = hpm_ff && !hpm_clr;
        case (flt_state_ff)
            cantx_pkg::CANTX_FLT_IDLE: begin
                if (rx_valid) begin
                    nxt_rx_ext = rx_ext;
                    nxt_rx_id = rx_id;
                    nxt_rd_idx = '0;
                    nxt_flt_state = cantx_pkg::CANTX_FLT_SCAN;
                end
            end
            cantx_pkg::CANTX_FLT_SCAN: begin
                // the bus owns the memory port while psel is high; the scan waits
                if (!psel && rd_idx_ff < FD_W) begin
                    nxt_rd_idx = rd_idx_ff + (FAW + 1)'(1);
                    nxt_rd_pend = 1'b1;
                end
                if (rd_pend_ff && !ev_idx[0]) begin
                    nxt_w0 = mem_rdata;
                end
                if (ev_now && ev_hit) begin
                    nxt_rd_pend = 1'b0;
                    nxt_flt_state = cantx_pkg::CANTX_FLT_IDLE;
                    if (ev_cfg == cantx_pkg::CANTX_FCFG_REJECT
                        || ev_cfg == cantx_pkg::CANTX_FCFG_RSVD) begin
                        nxt_rej = 1'b1;
                    end else begin
                        nxt_acc = 1'b1;
                        nxt_fsel = w0_ff[`CANTX_FE_CFG_LSB + 1];
                        if (w0_ff[`CANTX_FE_CFG_LSB + 2]) begin
                            nxt_hpm = 1'b1;
                            nxt_fsel = (ev_cfg == cantx_pkg::CANTX_FCFG_PRIO_F1);
                        end
                    end
                end else if (ev_now && ev_last) begin
                    // non-matching acceptance never raises the priority flag
                    nxt_rd_pend = 1'b0;
                    nxt_flt_state = cantx_pkg::CANTX_FLT_IDLE;
                    nxt_acc = (anf == `CANTX_ANF_FIFO0) || (anf == `CANTX_ANF_FIFO1);
                    nxt_rej = !nxt_acc;
                    nxt_fsel = (anf == `CANTX_ANF_FIFO1);
                end
            end
            default: nxt_flt_state = cantx_pkg::CANTX_FLT_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt_state_ff <= cantx_pkg::CANTX_FLT_IDLE;
            rd_idx_ff <= '0;
            rd_pend_ff <= 1'b0;
            w0_ff <= 32'h0000_0000;
            rx_ext_ff <= 1'b0;
            rx_id_ff <= 29'h0000_0000;
            acc_ff <= 1'b0;
            fsel_ff <= 1'b0;
            rej_ff <= 1'b0;
            hpm_ff <= 1'b0;
        end else begin
            flt_state_ff <= nxt_flt_state;
            rd_idx_ff <= nxt_rd_idx;
            rd_pend_ff <= nxt_rd_pend;
            w0_ff <= nxt_w0;
            rx_ext_ff <= nxt_rx_ext;
            rx_id_ff <= nxt_rx_id;
            acc_ff <= nxt_acc;
            fsel_ff <= nxt_fsel;
            rej_ff <= nxt_rej;
            hpm_ff <= nxt_hpm;
        end
    end

    cantx_filter_mem #(.W(32), .DEPTH(FD)) i_cantx_filter_mem (
        .clk(pclk),
        .rst_n(presetn),
        .addr(mem_addr),
        .we(apply_wr && in_flt),
        .wdata(pwdata),
        .rdata_ff(mem_rdata)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign tx_start = tx_start_ff;
    assign tx_buf = cur_ff;
    assign rx_accept = acc_ff;
    assign rx_fifo_sel = fsel_ff;
    assign rx_reject = rej_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_order_lowest: assert property (tx_start_ff |-> ($past(pend_ff) & below(cur_ff)) == '0)
        else $error("a lower pending buffer was skipped");
    chk_add_group: assert property (add_new != '0 |=> (pend_ff & $past(add_new)) == $past(add_new))
        else $error("added buffers did not all become pending");
    // the index lags pending by one cycle, so it is held against last cycle's vector
    chk_put_lowest: assert property (!put_full_ff
        |-> ($past(pend_ff) & (NBUF'(1) << put_idx_ff)) == '0
        && ($past(~pend_ff) & QMASK & below(put_idx_ff)) == '0)
        else $error("put index is not the lowest free queue buffer");
    chk_cancel_safe: assert property ((cf_ff & ~$past(cf_ff) & pend_ff) == '0)
        else $error("cancel finished while still pending");
    chk_frame_holds: assert property (tx_state_ff == cantx_pkg::CANTX_TX_ACTIVE && !tx_ok && !tx_fail
        |=> pend_ff[$past(cur_ff)] && !cf_ff[$past(cur_ff)])
        else $error("buffer released during its frame");
    chk_occurred_set: assert property (tx_state_ff == cantx_pkg::CANTX_TX_ACTIVE && tx_ok
        |=> to_ff[$past(cur_ff)] && !pend_ff[$past(cur_ff)] ##1 tx_state_ff == cantx_pkg::CANTX_TX_IDLE
        || tx_start_ff)
        else $error("occurred bit missing after success");
    chk_retry_kept: assert property (tx_state_ff == cantx_pkg::CANTX_TX_ACTIVE && tx_fail
        && !ctrl_ff[`CANTX_CTRL_DAR] && !creq_ff[cur_ff] && !cancel_new[cur_ff]
        |=> pend_ff[$past(cur_ff)] && !cf_ff[$past(cur_ff)])
        else $error("failed frame not kept for retry");
    chk_dar_noretry: assert property (tx_state_ff == cantx_pkg::CANTX_TX_ACTIVE && tx_fail
        && ctrl_ff[`CANTX_CTRL_DAR] |=> cf_ff[$past(cur_ff)] && !pend_ff[$past(cur_ff)])
        else $error("retry happened with retransmission disabled");
    chk_hpm_cause: assert property ($rose(hpm_ff) |-> $past(ev_now && ev_hit
        && w0_ff[`CANTX_FE_CFG_LSB + 2]))
        else $error("priority flag set without priority filter");
    chk_catchall_f0: assert property (ev_now && ev_hit && ev_cfg == cantx_pkg::CANTX_FCFG_FIFO0
        |=> rx_accept && !rx_fifo_sel && !rx_reject)
        else $error("fifo 0 filter did not store in fifo 0");
    chk_zero_mask: assert property (ev_now && ev_kind && ev_cfg == cantx_pkg::CANTX_FCFG_FIFO1
        && mem_rdata[`CANTX_FE_TYPE_LSB +: 2] == `CANTX_TYPE_CLASSIC
        && mem_rdata[`CANTX_FE_ID_MSB:0] == 29'h0000_0000 |=> rx_accept && rx_fifo_sel)
        else $error("zero mask filter did not catch the frame");
endmodule : cantx_order_cancel

// [verification/cantx_bus_node.sv]
// far-side bus node: ends each started frame with success or failure
`timescale 1ns/1ns
module cantx_bus_node #(
    parameter int DUR = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_start,
    input wire logic fail_next,
    output logic tx_ok,
    output logic tx_fail
);
    int cnt;
    // classic-length frames only, so a cancelled buffer is never rewritten mid-frame
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            tx_ok <= 1'b0;
            tx_fail <= 1'b0;
        end else begin
            tx_ok <= 1'b0;
            tx_fail <= 1'b0;
            if (tx_start) begin
                cnt <= DUR;
            end else if (cnt == 1) begin
                cnt <= 0;
                tx_ok <= !fail_next;
                tx_fail <= fail_next;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : cantx_bus_node

// [verification/tb_can_tx_order_cancel_filter.sv]
// self-checking bench for tx ordering, cancellation and catch-all filters
`timescale 1ns/1ns
`include "cantx_defs.svh"
module tb_can_tx_order_cancel_filter;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, m, tocc = 32'h0, cfin = 32'h0;
    logic pready, pslverr, tx_ok, tx_fail, tx_start, fail_next = 1'b0;
    logic rx_valid = 1'b0, rx_ext = 1'b0, rx_accept, rx_fifo_sel, rx_reject;
    logic [28:0] rx_id = 29'h0;
    logic re;
    logic [4:0] tx_buf;
    logic [32:0] exp_rd[$], exp_tx[$], exp_rx[$];
    int err_count = 0, compares = 0, ends = 0, starts = 0, rxn = 0, tot = 0, seed = 43;
    always #25 pclk = ~pclk;
    cantx_order_cancel i_cantx_order_cancel (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_ok(tx_ok), .tx_fail(tx_fail),
        .tx_start(tx_start), .tx_buf(tx_buf), .rx_valid(rx_valid), .rx_ext(rx_ext),
        .rx_id(rx_id), .rx_accept(rx_accept), .rx_fifo_sel(rx_fifo_sel), .rx_reject(rx_reject));
    cantx_bus_node i_cantx_bus_node (.pclk(pclk), .presetn(presetn), .tx_start(tx_start),
        .fail_next(fail_next), .tx_ok(tx_ok), .tx_fail(tx_fail));
    // ----------------------------------------------------------------
    // checking
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    always @(posedge pclk) begin
        if (pready && !pwrite) chk("prdata", exp_rd.pop_front(), {pslverr, prdata});
        if (tx_start) chk("tx_buf", exp_tx.pop_front(), 33'(tx_buf));
        if (rx_accept | rx_reject) chk("rx", exp_rx.pop_front(), 33'({rx_accept, rx_fifo_sel}));
        if (tx_ok | tx_fail) ends++;
        if (tx_start) starts++;
        if (rx_accept | rx_reject) rxn++;
    end
    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    task automatic wait_for(input int k, input int n);
        int i;
        i = 0;
        while ((k == 0 ? ends : (k == 1 ? starts : rxn)) < n && i < 3000) begin
            @(posedge pclk);
            i++;
        end
        if (i == 3000) begin
            err_count++;
            tally_and_finish();
        end
    endtask : wait_for
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int i;
        @(posedge pclk);
        if (!w) exp_rd.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50) begin
            err_count++;
            tally_and_finish();
        end
    endtask : apb
    task automatic add(input logic [31:0] b);
        tocc &= ~b;
        cfin &= ~b;
        apb(1'b1, `CANTX_OFF_ADD, b, 33'h0);
    endtask : add
    task automatic rx(input logic e, input logic sel);
        exp_rx.push_back(33'({1'b1, sel}));
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_ext <= e;
        rx_id <= 29'($random(seed));
        @(posedge pclk);
        rx_valid <= 1'b0;
        wait_for(2, rxn + 1);
    endtask : rx
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CANTX_OFF_CTRL, 0, 33'h0);
        apb(1'b0, `CANTX_OFF_PUT, 0, 33'h10);
        apb(1'b0, 12'h020, 0, 33'h100000000);
        apb(1'b1, `CANTX_OFF_PEND, 32'hFFFFFFFF, 33'h0);
        apb(1'b0, `CANTX_OFF_PEND, 0, 33'h0);
        m = $random(seed) | 32'h1;
        for (int i = 0; i < 32; i++) if (m[i]) begin
            exp_tx.push_back(33'(i));
            tot++;
        end
        add(m);
        wait_for(0, tot);
        tocc |= m;
        apb(1'b0, `CANTX_OFF_TOCC, 0, {1'b0, tocc});
        // buffer 9 is cancelled while buffer 1 is on the bus, so it never starts
        exp_tx.push_back(33'h1);
        exp_tx.push_back(33'h10);
        add(32'h00010202);
        wait_for(1, starts + 1);
        apb(1'b0, `CANTX_OFF_PUT, 0, 33'h11);
        apb(1'b1, `CANTX_OFF_CANCEL, 32'h200, 33'h0);
        wait_for(0, tot + 2);
        tot += 2;
        tocc |= 32'h00010002;
        cfin |= 32'h200;
        apb(1'b0, `CANTX_OFF_CFIN, 0, {1'b0, cfin});
        apb(1'b0, `CANTX_OFF_TOCC, 0, {1'b0, tocc});
        // failed attempt is retried while retransmission is on
        fail_next <= 1'b1;
        exp_tx.push_back(33'h3);
        exp_tx.push_back(33'h3);
        add(32'h8);
        wait_for(0, ++tot);
        fail_next <= 1'b0;
        wait_for(0, ++tot);
        // the same buffer carries the next message once its pending bit is clear
        exp_tx.push_back(33'h3);
        add(32'h8);
        wait_for(0, ++tot);
        tocc |= 32'h8;
        apb(1'b0, `CANTX_OFF_TOCC, 0, {1'b0, tocc});
        apb(1'b1, `CANTX_OFF_CTRL, 32'h1, 33'h0);
        fail_next <= 1'b1;
        exp_tx.push_back(33'h5);
        add(32'h20);
        wait_for(0, ++tot);
        fail_next <= 1'b0;
        cfin |= 32'h20;
        apb(1'b0, `CANTX_OFF_PEND, 0, 33'h0);
        apb(1'b0, `CANTX_OFF_CFIN, 0, {1'b0, cfin});
        // cancel during a frame: frame completes and is reported as sent
        apb(1'b1, `CANTX_OFF_CTRL, 32'h0, 33'h0);
        exp_tx.push_back(33'h7);
        add(32'h80);
        wait_for(1, starts + 1);
        apb(1'b1, `CANTX_OFF_CANCEL, 32'h80, 33'h0);
        apb(1'b0, `CANTX_OFF_PEND, 0, 33'h80);
        wait_for(0, ++tot);
        tocc |= 32'h80;
        apb(1'b0, `CANTX_OFF_TOCC, 0, {1'b0, tocc});
        apb(1'b0, `CANTX_OFF_CFIN, 0, {1'b0, cfin});
        // catch-all classic filters, global non-matching set to reject
        apb(1'b1, `CANTX_OFF_CTRL, 32'h1E, 33'h0);
        // unused elements are switched off so the scan never reads unknown words
        for (int k = 4; k < 16; k++) apb(1'b1, `CANTX_FLT_BASE + 12'(4 * k), 32'h0, 33'h0);
        apb(1'b1, `CANTX_FLT_BASE, {3'b010, 29'($random(seed))}, 33'h0);
        apb(1'b1, 12'h104, {`CANTX_TYPE_CLASSIC, 1'b0, 29'h0}, 33'h0);
        apb(1'b1, 12'h108, {3'b001, 29'($random(seed))}, 33'h0);
        apb(1'b1, 12'h10C, {`CANTX_TYPE_CLASSIC, 1'b1, 29'h0}, 33'h0);
        rx(1'b0, 1'b1);
        rx(1'b1, 1'b0);
        for (int k = 0; k < 4; k++) begin
            re = 1'($random(seed));
            rx(re, !re);
        end
        // priority element raises the flag; non-matching acceptance must leave it clear
        apb(1'b1, `CANTX_FLT_BASE, {3'b110, 29'($random(seed))}, 33'h0);
        rx(1'b0, 1'b1);
        apb(1'b0, `CANTX_OFF_STAT, 0, 33'h701);
        apb(1'b1, `CANTX_OFF_STAT, 32'h1, 33'h0);
        apb(1'b1, 12'h108, 32'h0, 33'h0);
        apb(1'b1, `CANTX_OFF_CTRL, 32'h0E, 33'h0);
        rx(1'b1, 1'b1);
        apb(1'b0, `CANTX_OFF_STAT, 0, 33'h700);
        tally_and_finish();
    end
endmodule : tb_can_tx_order_cancel_filter
